// >>> rtl/emulator_map_break_control.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - Load stack pointer on monitor entry after reset
// - Refuse odd or I/O-region reset stack value
// - Honour target reset in foreground when enabled
// - Disabled: ignore target reset and standby
// - Background monitor ignores reset and standby
// - Standby input acts as target reset
// - Reset setting or map change forces reset
// - Sixteen terms, 1K blocks, sizes rounded up
// - Five region types per map term
// - Suppress writes to emulation ROM
// - Guarded user access breaks immediately
// - Enabled write-to-ROM break on user writes
// - DMA writes never cause a break
// - Unmapped space defaults to target RAM
// - Internal RAM is emulation RAM, not listed
// - Refuse monitor access to guarded internal RAM
// - Enabled trap instruction breaks to monitor
// - Four triggers, each enabled to break
// - Stack value sets initial pointer only
module emulator_map_break_control #(
    parameter int TERMS = emu_ctrl_pkg::TERM_COUNT
) (
    input  wire logic                            clk_sys_in,
    input  wire logic                            rstn_in,
    // Host configuration
    input  wire logic                            cfg_sp_write_in,
    input  wire logic [31:0]                     cfg_sp_value_in,
    input  wire logic                            cfg_trst_write_in,
    input  wire logic                            cfg_trst_value_in,
    input  wire logic                            map_write_in,
    input  wire logic [3:0]                      map_index_in,
    input  wire logic                            map_enable_in,
    input  wire emu_ctrl_pkg::map_term_s         map_term_in,
    input  wire emu_ctrl_pkg::break_cfg_s        break_condition_cmd,
    input  wire logic                            iram_guard_in,
    input  wire logic                            mon_access_in,
    input  wire logic [23:0]                     mon_addr_in,
    // Processor side
    input  wire emu_ctrl_pkg::bus_cycle_s        cpu_cycle_in,
    input  wire logic                            trap_exec_in,
    input  wire logic                            monitor_active_in,
    input  wire logic                            emu_reset_exit_in,
    // Pins from target and triggers
    input  wire logic                            target_reset_in,
    input  wire logic                            target_standby_in,
    input  wire logic                            rear_trigger_in,
    input  wire logic                            coord_trigger_in,
    input  wire logic                            analyzer_trigger_one,
    input  wire logic                            analyzer_trigger_two,
    // Outputs
    output logic                                 sp_load_out,
    output logic [31:0]                          sp_value_out,
    output logic                                 cfg_sp_refused_out,
    output logic                                 emu_reset_out,
    output logic                                 break_req_out,
    output emu_ctrl_pkg::cause_e                 break_cause_out,
    output logic                                 write_enable_out,
    output logic                                 to_emulation_out,
    output emu_ctrl_pkg::region_e                region_out,
    output logic                                 mon_refused_out
);

    // Index port reaches sixteen terms at most
    if (TERMS < 1 || TERMS > emu_ctrl_pkg::TERM_COUNT) begin
        $error("TERMS must be 1..16");
    end

    // =====================================================================
    // Helper functions
    // =====================================================================
    // Address inside internal RAM
    function automatic logic in_iram(input logic [23:0] a);
        in_iram = (a >= emu_ctrl_pkg::IRAM_BASE) && (a <= emu_ctrl_pkg::IRAM_LIMIT);
    endfunction

    // ROM-type region
    function automatic logic is_rom(input emu_ctrl_pkg::region_e r);
        is_rom = (r == emu_ctrl_pkg::REGION_EROM) || (r == emu_ctrl_pkg::REGION_TROM);
    endfunction

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;

    // Two flops for every asynchronous pin
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {analyzer_trigger_two, analyzer_trigger_one, coord_trigger_in,
                             rear_trigger_in, ~(target_reset_in & target_standby_in)};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic [3:0] trig_last_reg;
    logic [3:0] trig_rise;

    // Trigger edge detect from synced levels
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) trig_last_reg <= 4'h0;
        else          trig_last_reg <= pin_sync_reg[4:1];
    end

    // Rising edge of each trigger
    assign trig_rise = pin_sync_reg[4:1] & ~trig_last_reg;

    // =====================================================================
    // Reset stack value
    // =====================================================================
    logic sp_bad;

    // Odd or inside the I/O register region
    assign sp_bad = cfg_sp_value_in[0] ||
                    ((cfg_sp_value_in[31:24] == 8'h00) &&
                     (cfg_sp_value_in[23:0] >= emu_ctrl_pkg::IO_BASE));

    // Store accepted value, refuse bad ones
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sp_value_out       <= emu_ctrl_pkg::RESET_SP_INIT;
            cfg_sp_refused_out <= 1'b0;
        end else begin
            cfg_sp_refused_out <= cfg_sp_write_in && sp_bad;
            if (cfg_sp_write_in && !sp_bad) sp_value_out <= cfg_sp_value_in;
        end
    end

    // Load pulse only on reset-to-monitor transition
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) sp_load_out <= 1'b0;
        else          sp_load_out <= emu_reset_exit_in && monitor_active_in;
    end

    // =====================================================================
    // Target reset gating and forced reset
    // =====================================================================
    logic trst_en_reg;
    logic tgt_rst;

    // Target-reset honour setting
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in)               trst_en_reg <= 1'b1;
        else if (cfg_trst_write_in) trst_en_reg <= cfg_trst_value_in;
    end

    // Standby merged into reset in the sync stage
    assign tgt_rst = pin_sync_reg[0] && trst_en_reg && !monitor_active_in;

    // Reset request from target or configuration change
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) emu_reset_out <= 1'b0;
        else          emu_reset_out <= tgt_rst || cfg_trst_write_in || map_write_in;
    end

    // =====================================================================
    // Map term storage
    // =====================================================================
    emu_ctrl_pkg::map_term_s term_reg [TERMS];
    logic [TERMS-1:0]        term_used_reg;

    // Terms written by host; power-on leaves none
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            term_used_reg <= '0;
            for (int i = 0; i < TERMS; i++) term_reg[i] <= '0;
        end else if (map_write_in && (int'(map_index_in) < TERMS)) begin
            term_used_reg[map_index_in] <= map_enable_in;
            term_reg[map_index_in]      <= map_term_in;
        end
    end

    // =====================================================================
    // Address decode
    // =====================================================================
    emu_ctrl_pkg::region_e   region_now;
    logic [emu_ctrl_pkg::BLK_W-1:0] blk;

    // Block number of the bus address
    assign blk = cpu_cycle_in.addr[emu_ctrl_pkg::ADDR_W-1:emu_ctrl_pkg::BLOCK_SHIFT];

    // First matching term wins; block granularity rounds sizes up
    always_comb begin
        region_now = emu_ctrl_pkg::REGION_TRAM;
        for (int i = TERMS - 1; i >= 0; i--) begin
            if (term_used_reg[i] && blk >= term_reg[i].first_blk &&
                blk <= term_reg[i].last_blk) begin
                region_now = term_reg[i].region;
            end
        end
        if (in_iram(cpu_cycle_in.addr)) begin
            region_now = iram_guard_in ? emu_ctrl_pkg::REGION_GUARD
                                       : emu_ctrl_pkg::REGION_ERAM;
        end
    end

    // Registered routing and write gate
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            region_out       <= emu_ctrl_pkg::REGION_TRAM;
            to_emulation_out <= 1'b0;
            write_enable_out <= 1'b0;
        end else begin
            region_out       <= region_now;
            to_emulation_out <= (region_now == emu_ctrl_pkg::REGION_EROM) ||
                                (region_now == emu_ctrl_pkg::REGION_ERAM);
            write_enable_out <= cpu_cycle_in.valid && cpu_cycle_in.write &&
                                !is_rom(region_now) &&
                                (region_now != emu_ctrl_pkg::REGION_GUARD);
        end
    end

    // Monitor access refusal to guarded internal RAM
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) mon_refused_out <= 1'b0;
        else          mon_refused_out <= mon_access_in && iram_guard_in &&
                                         in_iram(mon_addr_in);
    end

    // =====================================================================
    // Break logic
    // =====================================================================
    logic          user_cyc;
    logic          brk_guard;
    logic          brk_rom;
    logic          brk_bp;
    logic          brk_trig;
    logic [3:0]    trig_en;

    // Break sources; guard and ROM breaks on user cycles only
    assign user_cyc  = cpu_cycle_in.valid && !cpu_cycle_in.dma && !monitor_active_in;
    assign brk_guard = user_cyc && (region_now == emu_ctrl_pkg::REGION_GUARD);
    assign brk_rom   = user_cyc && cpu_cycle_in.write && is_rom(region_now) &&
                       break_condition_cmd.rom_write;
    assign brk_bp    = trap_exec_in && break_condition_cmd.soft_bp &&
                       !monitor_active_in;
    assign trig_en   = {break_condition_cmd.analyzer_two, break_condition_cmd.analyzer_one,
                        break_condition_cmd.coord_bus, break_condition_cmd.rear_panel};
    assign brk_trig  = |(trig_rise & trig_en) && !monitor_active_in;

    // Break request with priority cause
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            break_req_out   <= 1'b0;
            break_cause_out <= emu_ctrl_pkg::CAUSE_NONE;
        end else begin
            break_req_out <= brk_guard || brk_rom || brk_bp || brk_trig;
            if (brk_guard)     break_cause_out <= emu_ctrl_pkg::CAUSE_GUARD;
            else if (brk_rom)  break_cause_out <= emu_ctrl_pkg::CAUSE_ROM_WR;
            else if (brk_bp)   break_cause_out <= emu_ctrl_pkg::CAUSE_SOFT_BP;
            else if (brk_trig) break_cause_out <= emu_ctrl_pkg::CAUSE_TRIGGER;
            else               break_cause_out <= emu_ctrl_pkg::CAUSE_NONE;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    // All checks on the system clock
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    a_sp_load_pulse: assert property (
        emu_reset_exit_in && monitor_active_in |=> sp_load_out)
        else $error("stack load missing after reset exit");

    a_sp_reject_odd: assert property (
        cfg_sp_write_in && cfg_sp_value_in[0] |=> cfg_sp_refused_out && $stable(sp_value_out))
        else $error("odd stack value accepted");

    a_bg_ignores_pins: assert property (
        monitor_active_in && !cfg_trst_write_in && !map_write_in |=> !emu_reset_out)
        else $error("reset taken in background");

    a_trst_disabled: assert property (
        !trst_en_reg && !cfg_trst_write_in && !map_write_in |=> !emu_reset_out)
        else $error("reset taken while disabled");

    a_map_forces_reset: assert property (
        map_write_in || cfg_trst_write_in |=> emu_reset_out)
        else $error("config change without reset");

    a_rom_write_gate: assert property (
        cpu_cycle_in.valid && cpu_cycle_in.write && is_rom(region_now) |=> !write_enable_out)
        else $error("ROM write not suppressed");

    a_guard_breaks: assert property (
        brk_guard |=> break_req_out && break_cause_out == emu_ctrl_pkg::CAUSE_GUARD)
        else $error("guard access without break");

    a_dma_no_break: assert property (
        cpu_cycle_in.valid && cpu_cycle_in.dma && !trap_exec_in && !(|trig_rise)
        |=> !break_req_out)
        else $error("DMA cycle caused break");

    a_bp_disabled: assert property (
        trap_exec_in && !break_condition_cmd.soft_bp && !user_cyc && !(|trig_rise)
        |=> !break_req_out)
        else $error("disabled breakpoint broke");

    a_trst_honoured: assert property (
        tgt_rst |=> emu_reset_out)
        else $error("target reset ignored");

    a_standby_as_reset: assert property (
        !target_standby_in |=> pin_meta_reg[0])
        else $error("standby not taken as reset");

    a_rom_break: assert property (
        brk_rom |=> break_cause_out == emu_ctrl_pkg::CAUSE_ROM_WR)
        else $error("ROM write break missing");

    a_iram_emulated: assert property (
        in_iram(cpu_cycle_in.addr) && !iram_guard_in |=> to_emulation_out)
        else $error("internal RAM not emulated");

    a_mon_refusal: assert property (
        mon_access_in && iram_guard_in && in_iram(mon_addr_in) |=> mon_refused_out)
        else $error("guarded monitor access taken");

    a_soft_bp_break: assert property (
        brk_bp |=> break_req_out)
        else $error("trap did not break");

    // Main scenarios reached
    c_guard_break:   cover property (brk_guard ##1 break_req_out);
    c_rom_break:     cover property (brk_rom ##1 break_req_out);
    c_trigger_break: cover property (brk_trig ##1 break_req_out);
    c_sp_load:       cover property (sp_load_out);
    c_soft_bp_break: cover property (brk_bp ##1 break_req_out);

endmodule

`default_nettype wire

// >>> rtl/emu_ctrl_pkg.sv
package emu_ctrl_pkg;

    // =====================================================================
    // Widths and counts
    // =====================================================================
    localparam int          ADDR_W        = 24;
    localparam int          SP_W          = 32;
    localparam int          TERM_COUNT    = 16;
    localparam int          BLOCK_SHIFT   = 10;   // 1K byte blocks
    localparam int          BLK_W         = ADDR_W - BLOCK_SHIFT;

    // =====================================================================
    // Reset values and fixed regions
    // =====================================================================
    localparam logic [31:0] RESET_SP_INIT = 32'h0000_0000;
    localparam logic [23:0] IO_BASE       = 24'hFF_FC00;
    localparam logic [23:0] IO_LIMIT      = 24'hFF_FFFF;
    localparam logic [23:0] IRAM_BASE     = 24'hFF_B000;
    localparam logic [23:0] IRAM_LIMIT    = 24'hFF_EFFF;

    // =====================================================================
    // Region types
    // =====================================================================
    typedef enum logic [2:0] {
        REGION_EROM  = 3'b000,
        REGION_ERAM  = 3'b001,
        REGION_TROM  = 3'b010,
        REGION_TRAM  = 3'b011,
        REGION_GUARD = 3'b100
    } region_e;

    // Break cause codes
    typedef enum logic [2:0] {
        CAUSE_NONE    = 3'b000,
        CAUSE_GUARD   = 3'b001,
        CAUSE_ROM_WR  = 3'b010,
        CAUSE_SOFT_BP = 3'b011,
        CAUSE_TRIGGER = 3'b100
    } cause_e;

    // One map term as written by the host
    typedef struct packed {
        logic [BLK_W-1:0] first_blk;
        logic [BLK_W-1:0] last_blk;
        region_e          region;
    } map_term_s;

    // One processor bus cycle
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              dma;
        logic [ADDR_W-1:0] addr;
    } bus_cycle_s;

    // Break-condition enables
    typedef struct packed {
        logic rom_write;
        logic soft_bp;
        logic rear_panel;
        logic coord_bus;
        logic analyzer_one;
        logic analyzer_two;
    } break_cfg_s;

endpackage

// >>> sim/target_board_model.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Target board: reset and standby pins, trigger sources
// =====================================================================
module target_board_model (
    input  wire logic       clk_sys_in,
    output var  logic       reset_pin_out,
    output var  logic       standby_pin_out,
    output var  logic [3:0] trigger_out
);
    // Pins rest at pull-up level, triggers rest low
    initial begin
        reset_pin_out   = 1'h1;
        standby_pin_out = 1'h1;
        trigger_out     = 4'h0;
    end

    // Moves one active-low pin just after an edge
    task automatic set_pin(input logic standby, input logic level);
        @(posedge clk_sys_in);
        if (standby) begin
            standby_pin_out <= level;
        end else begin
            reset_pin_out <= level;
        end
    endtask

    // Moves one trigger line: 0 rear, 1 coordination, 2 and 3 analyzer
    task automatic set_trigger(input int idx, input logic level);
        @(posedge clk_sys_in);
        trigger_out[idx] <= level;
    endtask
endmodule

`default_nettype wire

// >>> sim/emulator_map_break_control_test.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Self-checking bench
// =====================================================================
module emulator_map_break_control_test;
    logic                      clk_sys_in = 1'h0;
    logic                      rstn_in    = 1'h0;
    logic                      sp_wr, trst_wr, trst_val, map_wr, map_en;
    logic                      iram_guard, mon_acc, trap, mon_act, rst_exit;
    logic [31:0]               sp_val;
    logic [3:0]                map_idx;
    logic [23:0]               mon_addr;
    emu_ctrl_pkg::map_term_s   term;
    emu_ctrl_pkg::break_cfg_s  bc;
    emu_ctrl_pkg::bus_cycle_s  cyc;
    logic                      treset, tstby, sp_load, sp_ref, emu_rst, brk;
    logic                      we, to_emu, mon_ref;
    logic [3:0]                trig;
    logic [31:0]               sp_value;
    emu_ctrl_pkg::cause_e      cause;
    emu_ctrl_pkg::region_e     region;
    int                        miscompares = 0;
    int                        checked     = 0;
    int                        cycles      = 0;

    // Clock at 20 MHz
    always #25 clk_sys_in = ~clk_sys_in;

    emulator_map_break_control u_emulator_map_break_control (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cfg_sp_write_in(sp_wr),
        .cfg_sp_value_in(sp_val), .cfg_trst_write_in(trst_wr), .cfg_trst_value_in(trst_val),
        .map_write_in(map_wr), .map_index_in(map_idx), .map_enable_in(map_en),
        .map_term_in(term), .break_condition_cmd(bc), .iram_guard_in(iram_guard),
        .mon_access_in(mon_acc), .mon_addr_in(mon_addr), .cpu_cycle_in(cyc),
        .trap_exec_in(trap), .monitor_active_in(mon_act), .emu_reset_exit_in(rst_exit),
        .target_reset_in(treset), .target_standby_in(tstby), .rear_trigger_in(trig[0]),
        .coord_trigger_in(trig[1]), .analyzer_trigger_one(trig[2]),
        .analyzer_trigger_two(trig[3]), .sp_load_out(sp_load), .sp_value_out(sp_value),
        .cfg_sp_refused_out(sp_ref), .emu_reset_out(emu_rst), .break_req_out(brk),
        .break_cause_out(cause), .write_enable_out(we), .to_emulation_out(to_emu),
        .region_out(region), .mon_refused_out(mon_ref));

    target_board_model u_target_board_model (
        .clk_sys_in(clk_sys_in), .reset_pin_out(treset),
        .standby_pin_out(tstby), .trigger_out(trig));

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // =====================================================================
    // Compare tasks
    // =====================================================================
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // =====================================================================
    // Drivers: one-cycle requests, outputs looked at one cycle later
    // =====================================================================
    task automatic finish_pulse();
        @(posedge clk_sys_in);
        {sp_wr, trst_wr, map_wr, mon_acc, trap, rst_exit} <= 6'h00;
        cyc.valid <= 1'h0;
        @(negedge clk_sys_in);
    endtask

    task automatic write_sp(input logic [31:0] v);
        @(posedge clk_sys_in);
        sp_wr  <= 1'h1;
        sp_val <= v;
        finish_pulse();
    endtask

    task automatic write_trst(input logic v);
        @(posedge clk_sys_in);
        trst_wr  <= 1'h1;
        trst_val <= v;
        finish_pulse();
        chk_bit(emu_rst, 1'h1, "reset after trst change");
    endtask

    task automatic write_map(input logic [3:0] idx, input logic [13:0] blk,
                             input emu_ctrl_pkg::region_e r);
        @(posedge clk_sys_in);
        map_wr  <= 1'h1;
        map_idx <= idx;
        map_en  <= 1'h1;
        term    <= '{first_blk: blk, last_blk: blk + 14'h0001, region: r};
        finish_pulse();
        chk_bit(emu_rst, 1'h1, "reset after map change");
    endtask

    task automatic bus(input logic wr, input logic dma, input logic [23:0] a);
        @(posedge clk_sys_in);
        cyc <= '{valid: 1'h1, write: wr, dma: dma, addr: a};
        finish_pulse();
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic test_stack_value();
        chk_val(sp_value, 32'h0000_0000, "stack value after reset");
        chk_val({29'h0, region}, 32'h0000_0003, "idle region");
        write_sp(32'h0000_0101);
        chk_bit(sp_ref, 1'h1, "odd stack refused");
        write_sp(32'h00FF_FC00);
        chk_bit(sp_ref, 1'h1, "io stack refused");
        chk_val(sp_value, 32'h0000_0000, "refused value kept");
        write_sp(32'h0000_FF00);
        chk_bit(sp_ref, 1'h0, "even stack accepted");
        @(posedge clk_sys_in);
        rst_exit <= 1'h1;
        mon_act  <= 1'h1;
        finish_pulse();
        chk_bit(sp_load, 1'h1, "stack load on entry");
        chk_val(sp_value, 32'h0000_FF00, "stack value loaded");
        @(posedge clk_sys_in);
        mon_act <= 1'h0;
        @(negedge clk_sys_in);
        chk_bit(sp_load, 1'h0, "stack load only once");
    endtask

    task automatic test_map_regions();
        logic [23:0] base;
        @(posedge clk_sys_in);
        bc <= 6'h20;
        for (int r = 0; r < 5; r++) begin
            base = {14'(16 + 2 * r), 10'h000};
            // Term 0 holds emulation ROM, as on-chip ROM needs
            write_map(4'(r), 14'(16 + 2 * r), emu_ctrl_pkg::region_e'(r));
            bus(1'h0, 1'h0, base + 24'h00_07FF);
            chk_val({29'h0, region}, 32'(r), "region of term");
            chk_bit(to_emu, r < 2, "emulation routing");
            chk_bit(brk, r == 4, "guard read break");
            bus(1'h1, 1'h0, base);
            chk_bit(we, r == 1 || r == 3, "rom write suppressed");
            chk_bit(brk, r != 1 && r != 3, "user write break");
            chk_val({29'h0, cause}, (r == 4) ? 1 : ((r == 1 || r == 3) ? 0 : 2),
                    "user write cause");
            bus(1'h1, 1'h1, base);
            chk_bit(brk, 1'h0, "dma write no break");
        end
        bus(1'h0, 1'h0, 24'h80_0000);
        chk_val({29'h0, region}, 32'h0000_0003, "unmapped is target ram");
        bus(1'h0, 1'h0, 24'hFF_B000);
        chk_val({29'h0, region}, 32'h0000_0001, "internal ram emulated");
        chk_bit(to_emu, 1'h1, "internal ram routing");
        @(posedge clk_sys_in);
        bc <= 6'h00;
        bus(1'h1, 1'h0, 24'h00_4000);
        chk_bit(brk, 1'h0, "rom write break off");
    endtask

    task automatic test_soft_break();
        for (int e = 1; e >= 0; e--) begin
            @(posedge clk_sys_in);
            bc   <= e ? 6'h10 : 6'h00;
            trap <= 1'h1;
            finish_pulse();
            chk_bit(brk, e == 1, "trap break");
            chk_val({29'h0, cause}, e ? 32'h0000_0003 : 32'h0000_0000, "trap cause");
        end
        @(posedge clk_sys_in);
        iram_guard <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_in);
            mon_acc  <= 1'h1;
            mon_addr <= k ? 24'h00_1000 : 24'hFF_B000;
            finish_pulse();
            chk_bit(mon_ref, k == 0, "monitor access refusal");
        end
        @(posedge clk_sys_in);
        iram_guard <= 1'h0;
    endtask

    // Pin low four cycles, checked after three, then back high and settle
    task automatic pin_case(input logic standby, input logic exp);
        u_target_board_model.set_pin(standby, 1'h0);
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk_bit(emu_rst, exp, "target pin reset");
        u_target_board_model.set_pin(standby, 1'h1);
        repeat (5) @(posedge clk_sys_in);
    endtask

    task automatic test_target_pins();
        pin_case(1'h0, 1'h1);
        pin_case(1'h1, 1'h1);
        mon_act <= 1'h1;
        pin_case(1'h0, 1'h0);
        pin_case(1'h1, 1'h0);
        mon_act <= 1'h0;
        write_trst(1'h0);
        repeat (2) @(posedge clk_sys_in);
        pin_case(1'h0, 1'h0);
        pin_case(1'h1, 1'h0);
        write_trst(1'h1);
    endtask

    task automatic test_triggers();
        for (int i = 0; i < 4; i++) begin
            for (int e = 0; e < 2; e++) begin
                @(posedge clk_sys_in);
                bc <= e ? emu_ctrl_pkg::break_cfg_s'(6'h01 << (3 - i)) : 6'h00;
                u_target_board_model.set_trigger(i, 1'h1);
                repeat (3) @(posedge clk_sys_in);
                @(negedge clk_sys_in);
                chk_bit(brk, e == 1, "trigger break");
                chk_val({29'h0, cause}, e ? 32'h0000_0004 : 32'h0000_0000, "trigger cause");
                u_target_board_model.set_trigger(i, 1'h0);
                repeat (4) @(posedge clk_sys_in);
            end
        end
    endtask

    // Main sequence
    initial begin
        {sp_wr, trst_wr, trst_val, map_wr, map_en, iram_guard} = 6'h00;
        {mon_acc, trap, mon_act, rst_exit} = 4'h0;
        {sp_val, map_idx, mon_addr} = 60'h0;
        term = '0;
        bc   = '0;
        cyc  = '0;
        repeat (2) @(posedge clk_sys_in);
        rstn_in <= 1'h1;
        @(negedge clk_sys_in);
        test_stack_value();
        test_map_regions();
        test_soft_break();
        test_target_pins();
        test_triggers();
        conclude();
    end
endmodule

`default_nettype wire
